// ---- pkg/prom_prog_pkg.sv ----
// Constants shared by the PROM programmer controller
package prom_prog_pkg;
  localparam int CLK_MHZ = 125;
  localparam int PULSE_US_X10 = 1000;
  localparam int PULSE_CYC = (PULSE_US_X10 * CLK_MHZ + 9) / 10;
  localparam int SETUP_CYC = 4;
  localparam int SAMPLE_CYC = 8;
  localparam int MAX_TRIES = 10;
  localparam int PAGE_BYTES = 4;
  localparam int ADDR_W = 17;
  localparam logic [16:0] ADDR_TOP = 17'h1FFFF;
  localparam logic [16:0] ADDR_RST = 17'h00000;
  localparam logic [7:0] DATA_RST = 8'h00;
  typedef enum logic [1:0] {OP_READ, OP_BYTE, OP_PAGE} op_t;
endpackage

// ---- hw/prom_timer.sv ----
// Down counter that times strobe phases of the programmer
`timescale 1ns/1ps
module prom_timer
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic start,
  input wire logic [16:0] load,
  output logic done
);
  logic [16:0] cnt_q;
  logic [16:0] cnt_d;
  logic run_q;
  logic run_d;

  assign cnt_d = start ? load : (run_q ? cnt_q - 17'h00001 : cnt_q);
  assign run_d = start ? 1'b1 : (run_q && cnt_q != 17'h00001);
  assign done = run_q && cnt_q == 17'h00001;

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      cnt_q <= 17'h00000;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end
endmodule // prom_timer

// ---- hw/prom_programmer.sv ----
// Host-side programmer that drives the one-time PROM port pins
// Summary of operation
// - Hold reset low, supplies high before any write operation.
// - Page latch: select high, program pulse high, strobe low, four bytes.
// - Page write: select and strobe high, program pulse low for 0.1 ms.
// - Byte write: select low, strobe high, program pulse low 0.1 ms.
// - Verify with select low, pulse high, strobe low after every write.
// - Write and verify at most ten times per request; the four bytes of a page share one count.
// - Read: reset low, supplies normal, address set, then sample data.
`timescale 1ns/1ps
module prom_programmer
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_OP,
  input wire logic [16:0] REQ_ADDR,
  input wire logic [31:0] REQ_DATA,
  output logic REQ_READY,
  output logic DONE,
  output logic FAIL,
  output logic [7:0] RD_DATA,
  output logic [16:0] PROM_ADDRESS_BUS,
  output logic [7:0] PROM_DATA_BUS_O,
  output logic PROM_DATA_BUS_OE_N,
  input wire logic [7:0] PROM_DATA_BUS_I,
  output logic CHIP_SELECT_N,
  output logic READ_STROBE_N,
  output logic PROGRAM_PULSE_N,
  output logic DEV_RESET_N,
  output logic VPP_HIGH,
  output logic VDD_HIGH
);
  typedef enum {S_IDLE, S_PWR, S_LATCH, S_LATCH_GAP, S_PULSE, S_GAP, S_VERIFY,
                S_CHECK, S_READ, S_END} state_t;
  state_t st_q;
  state_t st_d;
  logic [7:0] din1_q, din2_q, din3_q, din_q;
  logic [16:0] base_q;
  logic [31:0] page_q;
  logic [1:0] op_q;
  logic [1:0] idx_q;
  logic [3:0] tries_q;
  logic bad_q;
  logic t_start;
  logic [16:0] t_load;
  logic t_done;
  logic [16:0] cur_addr;
  logic [7:0] cur_byte;
  logic is_prog;
  logic last_byte;
  logic take;
  logic [1:0] op_nx;
  logic prog_nx;
  logic byte_hold;

  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] i);
    pick = w[8*i +: 8];
  endfunction

  assign cur_addr = base_q + {15'h0000, idx_q};
  assign cur_byte = pick(page_q, idx_q);
  assign is_prog = op_q != 2'(prom_prog_pkg::OP_READ);
  assign last_byte = op_q != 2'(prom_prog_pkg::OP_PAGE) || idx_q == 2'h3;
  // A request counts only while ready is shown, never in the cycle after reset
  assign take = st_q == S_IDLE && REQ_VALID && REQ_READY;
  assign op_nx = take ? REQ_OP : op_q;
  // Supplies follow the op being taken, not the one before it
  assign prog_nx = op_nx != 2'(prom_prog_pkg::OP_READ);
  // Byte write keeps select and data up around the pulse for setup and hold
  assign byte_hold = op_nx == 2'(prom_prog_pkg::OP_BYTE)
                     && (st_d == S_PWR || st_d == S_PULSE || st_d == S_GAP);

  prom_timer u_tmr
  (
    .CLK(CLK),
    .SRST(SRST),
    .start(t_start),
    .load(t_load),
    .done(t_done)
  );

  always_comb
  begin
    st_d = st_q;
    t_start = 1'b0;
    t_load = 17'(prom_prog_pkg::SETUP_CYC);
    case (st_q)
      S_IDLE:
        if (take)
        begin
          st_d = S_PWR;
          t_start = 1'b1;
        end
      S_PWR:
        if (t_done)
        begin
          t_start = 1'b1;
          if (!is_prog)
          begin
            st_d = S_READ;
            t_load = 17'(prom_prog_pkg::SAMPLE_CYC);
          end
          else if (op_q == 2'(prom_prog_pkg::OP_PAGE))
            st_d = S_LATCH;
          else
          begin
            st_d = S_PULSE;
            t_load = 17'(prom_prog_pkg::PULSE_CYC);
          end
        end
      S_LATCH:
        if (t_done)
        begin
          t_start = 1'b1;
          st_d = S_LATCH_GAP;
        end
      S_LATCH_GAP:
        if (t_done)
        begin
          t_start = 1'b1;
          if (idx_q == 2'h3)
          begin
            st_d = S_PULSE;
            t_load = 17'(prom_prog_pkg::PULSE_CYC);
          end
          else
            st_d = S_LATCH;
        end
      S_PULSE:
        if (t_done)
        begin
          t_start = 1'b1;
          st_d = S_GAP;
        end
      S_GAP:
        if (t_done)
        begin
          t_start = 1'b1;
          t_load = 17'(prom_prog_pkg::SAMPLE_CYC);
          st_d = S_VERIFY;
        end
      S_VERIFY:
        if (t_done)
          st_d = S_CHECK;
      S_CHECK:
      begin
        t_start = 1'b1;
        if (bad_q && tries_q < 4'(prom_prog_pkg::MAX_TRIES))
        begin
          st_d = S_PULSE;
          t_load = 17'(prom_prog_pkg::PULSE_CYC);
        end
        else if (bad_q || last_byte)
          st_d = S_END;
        else
        begin
          t_load = 17'(prom_prog_pkg::SAMPLE_CYC);
          st_d = S_VERIFY;
        end
      end
      S_READ:
        if (t_done)
          st_d = S_END;
      S_END:
        st_d = S_IDLE;
      default:
        st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    din1_q <= PROM_DATA_BUS_I;
    din2_q <= din1_q;
    din3_q <= din2_q;
    if (din2_q == din3_q)
      din_q <= din3_q;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      st_q <= S_IDLE;
      base_q <= prom_prog_pkg::ADDR_RST;
      page_q <= 32'h00000000;
      op_q <= 2'h0;
      idx_q <= 2'h0;
      tries_q <= 4'h0;
      bad_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (take)
      begin
        base_q <= REQ_OP == 2'(prom_prog_pkg::OP_PAGE) ? {REQ_ADDR[16:2], 2'h0} : REQ_ADDR;
        page_q <= REQ_DATA;
        op_q <= REQ_OP;
        idx_q <= 2'h0;
        tries_q <= 4'h0;
      end
      if (st_q == S_LATCH_GAP && t_done && idx_q != 2'h3)
        idx_q <= idx_q + 2'h1;
      if (st_q == S_PULSE && t_done)
        tries_q <= tries_q + 4'h1;
      if (st_q == S_LATCH_GAP && t_done && idx_q == 2'h3)
        idx_q <= 2'h0;
      if (st_q == S_VERIFY && t_done)
        bad_q <= din_q != cur_byte;
      if (st_q == S_CHECK && !bad_q && !last_byte)
        idx_q <= idx_q + 2'h1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      REQ_READY <= 1'b0;
      DONE <= 1'b0;
      FAIL <= 1'b0;
      RD_DATA <= prom_prog_pkg::DATA_RST;
      PROM_ADDRESS_BUS <= prom_prog_pkg::ADDR_RST;
      PROM_DATA_BUS_O <= prom_prog_pkg::DATA_RST;
      PROM_DATA_BUS_OE_N <= 1'b1;
      CHIP_SELECT_N <= 1'b1;
      READ_STROBE_N <= 1'b1;
      PROGRAM_PULSE_N <= 1'b1;
      DEV_RESET_N <= 1'b0;
      VPP_HIGH <= 1'b0;
      VDD_HIGH <= 1'b0;
    end
    else
    begin
      REQ_READY <= st_d == S_IDLE;
      DONE <= st_q == S_END;
      FAIL <= st_q == S_END && bad_q && is_prog;
      if (st_q == S_READ && t_done)
        RD_DATA <= din_q;
      DEV_RESET_N <= 1'b0;
      VPP_HIGH <= st_d != S_IDLE && st_d != S_END && prog_nx;
      VDD_HIGH <= st_d != S_IDLE && st_d != S_END && prog_nx;
      PROM_ADDRESS_BUS <= cur_addr;
      PROM_DATA_BUS_O <= cur_byte;
      CHIP_SELECT_N <= !(st_d == S_VERIFY || st_d == S_READ || byte_hold);
      READ_STROBE_N <= !(st_d == S_LATCH || st_d == S_VERIFY || st_d == S_READ);
      PROGRAM_PULSE_N <= st_d != S_PULSE;
      PROM_DATA_BUS_OE_N <= !(st_d == S_LATCH || st_d == S_LATCH_GAP || byte_hold);
    end
  end
endmodule // prom_programmer

// ---- bench/prom_model.sv ----
// Behavioural model of the one-time PROM programming port
`timescale 1ns/1ps
module prom_model
(
  input wire logic [16:0] a,
  input wire logic [7:0] d_o,
  input wire logic d_oe_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic pgm_n,
  input wire logic rst_n,
  input wire logic vpp,
  input wire logic vdd,
  output logic [7:0] d_i
);
  logic [7:0] mem [int];
  logic [7:0] page [4];
  logic [16:0] base;
  logic [7:0] last = 8'h00;
  always @(a, d_o, d_oe_n, ce_n, oe_n, pgm_n, rst_n, vpp, vdd)
    if (!rst_n && vpp && vdd && ce_n && !oe_n && pgm_n && !d_oe_n)
    begin
      page[a[1:0]] = d_o;
      base = a;
    end
  always @(posedge pgm_n)
    if (!rst_n && vpp && vdd && oe_n)
    begin
      if (ce_n)
        for (int i = 0; i < 4; i++)
          mem[{base[16:2], i[1:0]}] = page[i];
      else
        mem[a] = d_o;
    end
  always @(a, ce_n, oe_n, pgm_n)
    if (!ce_n && !oe_n && pgm_n)
    begin
      // Unwritten cells read as erased
      d_i = mem.exists(a) ? mem[a] : 8'hFF;
      last = d_i;
    end
    else
      d_i = ~last;
endmodule // prom_model

// ---- bench/prom_programmer_checker.sv ----
// Port-level checks for the PROM programmer
`timescale 1ns/1ps
module prom_programmer_checker
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic DONE,
  input wire logic PROM_DATA_BUS_OE_N,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic PROGRAM_PULSE_N,
  input wire logic DEV_RESET_N,
  input wire logic VPP_HIGH,
  input wire logic VDD_HIGH
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  int low_q;
  int since_q;
  int tries_q;
  always_ff @(posedge CLK)
  begin
    low_q <= (SRST || PROGRAM_PULSE_N) ? 0 : low_q + 1;
    since_q <= (SRST || !CHIP_SELECT_N && !READ_STROBE_N) ? 0 : since_q + 1;
    tries_q <= (SRST || REQ_VALID && REQ_READY) ? 0 : tries_q + $fell(PROGRAM_PULSE_N);
  end
  sequence s_verify;
    !CHIP_SELECT_N && !READ_STROBE_N && PROGRAM_PULSE_N;
  endsequence
  sequence s_latch;
    CHIP_SELECT_N && !READ_STROBE_N && PROGRAM_PULSE_N;
  endsequence
  sequence s_byte_end;
    !PROGRAM_PULSE_N && !CHIP_SELECT_N ##1 PROGRAM_PULSE_N;
  endsequence
  a_latch_drive: assert property (s_latch |-> !PROM_DATA_BUS_OE_N)
    else $error("latch without data");
  a_byte_drive: assert property (!PROGRAM_PULSE_N && !CHIP_SELECT_N |-> !PROM_DATA_BUS_OE_N)
    else $error("byte pulse without data");
  a_byte_hold: assert property (s_byte_end |-> !CHIP_SELECT_N && !PROM_DATA_BUS_OE_N)
    else $error("byte pulse end without hold");
  a_reset_held: assert property (!DEV_RESET_N) else $error("reset released");
  a_pulse_supply: assert property (!PROGRAM_PULSE_N |-> VPP_HIGH && VDD_HIGH)
    else $error("pulse without supplies");
  a_pulse_strobe: assert property (!PROGRAM_PULSE_N |-> READ_STROBE_N)
    else $error("pulse with strobe low");
  a_pulse_width: assert property ($rose(PROGRAM_PULSE_N) |-> low_q == prom_prog_pkg::PULSE_CYC)
    else $error("pulse width wrong");
  a_no_contention: assert property (!PROM_DATA_BUS_OE_N |-> not s_verify)
    else $error("bus contention");
  a_verify_done: assert property (DONE |-> since_q < 16)
    else $error("done without verify");
  a_try_limit: assert property (tries_q <= prom_prog_pkg::MAX_TRIES)
    else $error("too many pulses");
  a_idle_standby: assert property (REQ_READY |-> CHIP_SELECT_N && PROGRAM_PULSE_N)
    else $error("idle not standby");
endmodule // prom_programmer_checker
bind prom_programmer prom_programmer_checker chk (.CLK, .SRST, .REQ_VALID, .REQ_READY, .DONE,
  .PROM_DATA_BUS_OE_N, .CHIP_SELECT_N, .READ_STROBE_N, .PROGRAM_PULSE_N, .DEV_RESET_N,
  .VPP_HIGH, .VDD_HIGH);

// ---- bench/tb_top.sv ----
// Self-checking bench for the PROM programmer
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic [1:0] REQ_OP = 2'h0;
  logic [16:0] REQ_ADDR = 17'h00000;
  logic [31:0] REQ_DATA = 32'h00000000;
  logic REQ_READY, DONE, FAIL, PROM_DATA_BUS_OE_N, CHIP_SELECT_N, READ_STROBE_N;
  logic PROGRAM_PULSE_N, DEV_RESET_N, VPP_HIGH, VDD_HIGH;
  logic [7:0] RD_DATA, PROM_DATA_BUS_O, PROM_DATA_BUS_I;
  logic [16:0] PROM_ADDRESS_BUS;
  int num_errors = 0;
  int compares = 0;
  always #4 CLK = ~CLK;
  prom_programmer DUT (.CLK, .SRST, .REQ_VALID, .REQ_OP, .REQ_ADDR, .REQ_DATA, .REQ_READY,
    .DONE, .FAIL, .RD_DATA, .PROM_ADDRESS_BUS, .PROM_DATA_BUS_O, .PROM_DATA_BUS_OE_N,
    .PROM_DATA_BUS_I, .CHIP_SELECT_N, .READ_STROBE_N, .PROGRAM_PULSE_N, .DEV_RESET_N,
    .VPP_HIGH, .VDD_HIGH);
  prom_model MODEL (.a(PROM_ADDRESS_BUS), .d_o(PROM_DATA_BUS_O), .d_oe_n(PROM_DATA_BUS_OE_N),
    .ce_n(CHIP_SELECT_N), .oe_n(READ_STROBE_N), .pgm_n(PROGRAM_PULSE_N), .rst_n(DEV_RESET_N),
    .vpp(VPP_HIGH), .vdd(VDD_HIGH), .d_i(PROM_DATA_BUS_I));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input prom_prog_pkg::op_t o, input logic [16:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ_OP <= o;
    REQ_ADDR <= a;
    REQ_DATA <= d;
    // Ready only moves on a rising edge, so its level at the falling edge is what is sampled
    n = 0;
    @(negedge CLK);
    while (REQ_READY !== 1'b1 && n < 50)
    begin
      @(negedge CLK);
      n++;
    end
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while (DONE !== 1'b1 && n < 20000);
    chk(DONE, 1'b1);
    chk(FAIL, 1'b0);
  endtask
  // Byte write at the top address, then read back
  task automatic byte_top();
    op(prom_prog_pkg::OP_BYTE, prom_prog_pkg::ADDR_TOP, 32'h0000005A);
    op(prom_prog_pkg::OP_READ, prom_prog_pkg::ADDR_TOP, 32'h00000000);
    chk(RD_DATA, 8'h5A);
  endtask
  // Unaligned page request; every byte lands in order
  task automatic page_rd();
    op(prom_prog_pkg::OP_PAGE, 17'h00006, 32'hC3A51E87);
    for (int i = 0; i < 4; i++)
    begin
      op(prom_prog_pkg::OP_READ, 17'(4 + i), 32'h00000000);
      chk(RD_DATA, 8'(32'hC3A51E87 >> (8 * i)));
    end
  endtask
  // Neighbours of the page stay erased
  task automatic blank_rd();
    op(prom_prog_pkg::OP_READ, 17'h00003, 32'h00000000);
    chk(RD_DATA, 8'hFF);
    op(prom_prog_pkg::OP_READ, 17'h00008, 32'h00000000);
    chk(RD_DATA, 8'hFF);
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge CLK);
    num_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (5) @(posedge CLK);
    SRST <= 1'b0;
    byte_top();
    page_rd();
    blank_rd();
    end_of_test();
  end
endmodule // tb_top
